// File: logic/emwc_core.sv
// Emulation memory wait, address wait and idle cycle controller with APB.
// Assumes pclk at 10 MHz and presetn asynchronous active low.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/10ps

module emwc_core
  import emwc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] emulation_memory_wait_mask_select,
  input wire emwc_req_t req,
  output emwc_ans_t ans
);

  initial begin
    if (ADDR_W < 5) begin
      $error("ADDR_W too small for the register map");
    end
  end

  logic [3:0] ctrl_ff;
  logic [3:0] data_wait_config_ff;
  logic [1:0] address_wait_config_ff;
  logic [1:0] bcc_ff;
  logic [7:0] freq_ff;
  logic [1:0] mode_ff;
  logic [7:0] acc_cnt_ff;
  logic [7:0] map_err_cnt_ff;
  emwc_ans_t ans_ff;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [1:0] freq_waits;
  logic emu_ok;
  emwc_mode_t cur_mode;
  logic [3:0] d_w;
  logic [1:0] a_w;
  logic [1:0] i_c;
  logic ew;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  function automatic logic known(input logic [ADDR_W-1:0] a);
    logic [11:0] b;
    b = 12'(a);
    known = (b == `EMWC_OFS_CTRL) || (b == `EMWC_OFS_DWC) ||
            (b == `EMWC_OFS_AWC) || (b == `EMWC_OFS_BCC) ||
            (b == `EMWC_OFS_FREQ) || (b == `EMWC_OFS_STAT) ||
            (b == `EMWC_OFS_ID);
  endfunction : known

  assign hit = known(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_en = psel && !penable && !pwrite;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 4'h0;
      data_wait_config_ff <= `EMWC_DWC_RST;
      address_wait_config_ff <= `EMWC_AWC_RST;
      bcc_ff <= `EMWC_BCC_RST;
      freq_ff <= `EMWC_FREQ_RST;
    end else if (wr_en) begin
      unique case (12'(paddr))
        `EMWC_OFS_CTRL: begin
          // Width bit only writes 1 (16 bit) or 0 (32 bit); no 8 bit code
          ctrl_ff <= {pwdata[`EMWC_CTRL_MAP64_BIT],
                      pwdata[`EMWC_CTRL_WIDTH_BIT], 2'h0};
        end
        `EMWC_OFS_DWC: data_wait_config_ff <= pwdata[3:0];
        `EMWC_OFS_AWC: address_wait_config_ff <= pwdata[1:0];
        `EMWC_OFS_BCC: bcc_ff <= pwdata[1:0];
        `EMWC_OFS_FREQ: freq_ff <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      unique case (12'(paddr))
        `EMWC_OFS_CTRL: prdata <= {28'h0, ctrl_ff};
        `EMWC_OFS_DWC: prdata <= {28'h0, data_wait_config_ff};
        `EMWC_OFS_AWC: prdata <= {30'h0, address_wait_config_ff};
        `EMWC_OFS_BCC: prdata <= {30'h0, bcc_ff};
        `EMWC_OFS_FREQ: prdata <= {24'h0, freq_ff};
        `EMWC_OFS_STAT: prdata <= {14'h0, mode_ff, map_err_cnt_ff,
                                   acc_cnt_ff};
        `EMWC_OFS_ID: prdata <= `EMWC_ID_VALUE;
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Frequency band
  // ----------------------------------------------------------------------
  always_comb begin
    if (freq_ff > `EMWC_FREQ_TWO_MHZ) begin
      freq_waits = 2'h2;
    end else if (freq_ff >= `EMWC_FREQ_ONE_MHZ) begin
      freq_waits = 2'h1;
    end else begin
      freq_waits = 2'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Mode sampling and map limit
  // ----------------------------------------------------------------------
  assign emu_ok = req.emu && !(ctrl_ff[`EMWC_CTRL_MAP64_BIT] &&
                  (req.addr >= `EMWC_MAP64_LIMIT));
  assign cur_mode = emwc_mode_t'(emulation_memory_wait_mask_select);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 2'h0;
    end else if (req.valid) begin
      mode_ff <= emulation_memory_wait_mask_select;
    end
  end

  emwc_decide u_decide (
    .mode(cur_mode),
    .freq_waits(freq_waits),
    .data_wait_config(data_wait_config_ff),
    .address_wait_config(address_wait_config_ff),
    .bcc(bcc_ff),
    .emu(emu_ok),
    .data_waits(d_w),
    .addr_waits(a_w),
    .idle_cycles(i_c),
    .ext_wait_en(ew)
  );

  // ----------------------------------------------------------------------
  // Registered answer, one cycle after the request
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ans_ff <= '0;
    end else begin
      ans_ff.valid <= req.valid;
      ans_ff.emu_hit <= req.valid && emu_ok;
      ans_ff.data_waits <= d_w;
      ans_ff.addr_waits <= a_w;
      ans_ff.idle_cycles <= i_c;
      ans_ff.ext_wait_en <= ew;
    end
  end

  assign ans = ans_ff;

  // ----------------------------------------------------------------------
  // Status counters
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_cnt_ff <= 8'h0;
      map_err_cnt_ff <= 8'h0;
    end else if (req.valid) begin
      acc_cnt_ff <= acc_cnt_ff + 8'h1;
      if (req.emu && !emu_ok) begin
        map_err_cnt_ff <= map_err_cnt_ff + 8'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  emu_addr_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && emu_ok |=> ans.addr_waits == 2'h0 && !ans.ext_wait_en)
    else $error("emulation access got address waits");

  map_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && ctrl_ff[3] && req.addr >= `EMWC_MAP64_LIMIT
    |=> !ans.emu_hit)
    else $error("emulation mapped above 64 MB limit");

  mask_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && emu_ok && cur_mode == EMWC_MODE_MASK
    |=> ans.data_waits == {2'h0, $past(freq_waits)})
    else $error("mask mode data waits wrong");

  one_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && emu_ok && cur_mode == EMWC_MODE_ONE
    |=> ans.data_waits == 4'h1 + {2'h0, $past(freq_waits)})
    else $error("one-wait mode data waits wrong");

  target_min_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && emu_ok && cur_mode == EMWC_MODE_TARGET
    |=> ans.data_waits != 4'h0)
    else $error("target mode gave zero waits");

  idle_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && emu_ok && cur_mode != EMWC_MODE_TARGET
    |=> ans.idle_cycles == 2'h0)
    else $error("idle cycles in mask or one-wait mode");

  freq_band_a: assert property (@(posedge pclk) disable iff (!presetn)
    freq_ff > 8'h28 |-> freq_waits == 2'h2)
    else $error("frequency band above 40 MHz wrong");

  ext_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && !req.emu && cur_mode == EMWC_MODE_MASK
    |=> !ans.ext_wait_en)
    else $error("wait pin not masked in mask mode");

  mode_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid |=> mode_ff == $past(emulation_memory_wait_mask_select))
    else $error("mode not sampled at access start");

endmodule : emwc_core

// File: logic/emwc_decide.sv
// Combinational wait decision for one access.
// Assumes mode and configuration are stable while req.valid is high.
`timescale 1ns/10ps

module emwc_decide
  import emwc_pkg::*;
(
  input wire emwc_mode_t mode,
  input wire logic [1:0] freq_waits,
  input wire logic [3:0] data_wait_config,
  input wire logic [1:0] address_wait_config,
  input wire logic [1:0] bcc,
  input wire logic emu,
  output logic [3:0] data_waits,
  output logic [1:0] addr_waits,
  output logic [1:0] idle_cycles,
  output logic ext_wait_en
);

  logic [3:0] emu_data;

  // ----------------------------------------------------------------------
  // Emulation memory data waits
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (mode)
      EMWC_MODE_MASK: emu_data = 4'h0;
      EMWC_MODE_ONE: emu_data = 4'h1;
      EMWC_MODE_TARGET: emu_data = (data_wait_config == 4'h0) ? 4'h1 : data_wait_config;
      default: emu_data = 4'h0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Final selection
  // ----------------------------------------------------------------------
  always_comb begin
    if (emu) begin
      // Frequency floor added on top of the mode count
      data_waits = emu_data + {2'h0, freq_waits};
      addr_waits = 2'h0;
      idle_cycles = (mode == EMWC_MODE_TARGET) ? bcc : 2'h0;
      ext_wait_en = 1'b0;
    end else begin
      data_waits = data_wait_config;
      addr_waits = address_wait_config;
      idle_cycles = bcc;
      ext_wait_en = (mode != EMWC_MODE_MASK);
    end
  end

endmodule : emwc_decide

// File: logic/emwc_pkg.sv
// Types shared by the emulation memory wait controller files.
// Assumes the constants header is on the include path.
package emwc_pkg;

  `include "emwc_regs.svh"

  typedef enum logic [1:0] {
    EMWC_MODE_MASK,
    EMWC_MODE_ONE,
    EMWC_MODE_TARGET,
    EMWC_MODE_RSVD
  } emwc_mode_t;

  // Access request from the emulated processor bus
  typedef struct packed {
    logic valid;
    logic emu;
    logic [31:0] addr;
  } emwc_req_t;

  // Wait decision answered to the bus interface
  typedef struct packed {
    logic valid;
    logic emu_hit;
    logic [3:0] data_waits;
    logic [1:0] addr_waits;
    logic [1:0] idle_cycles;
    logic ext_wait_en;
  } emwc_ans_t;

endpackage : emwc_pkg

// File: logic/emwc_regs.svh
// Register offsets, field positions, reset values and frequency thresholds of the
// emulation memory wait controller. Included by the package only; the core imports the package.
`ifndef EMWC_REGS_SVH
`define EMWC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------------
`define EMWC_OFS_CTRL 12'h000
`define EMWC_OFS_DWC 12'h004
`define EMWC_OFS_AWC 12'h008
`define EMWC_OFS_BCC 12'h00c
`define EMWC_OFS_FREQ 12'h010
`define EMWC_OFS_STAT 12'h014
`define EMWC_OFS_ID 12'h018

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define EMWC_CTRL_MODE_LSB 0
`define EMWC_CTRL_WIDTH_BIT 2
`define EMWC_CTRL_MAP64_BIT 3
`define EMWC_CTRL_RST 32'h0000_0000
`define EMWC_DWC_RST 4'h7
`define EMWC_AWC_RST 2'h3
`define EMWC_BCC_RST 2'h3
`define EMWC_FREQ_RST 8'h0a

// ----------------------------------------------------------------------
// Frequency thresholds in MHz
// ----------------------------------------------------------------------
`define EMWC_FREQ_ONE_MHZ 8'h19
`define EMWC_FREQ_TWO_MHZ 8'h28

// Emulation memory upper bound in 64 MB mode
`define EMWC_MAP64_LIMIT 32'h0400_0000

// Arbitrary identification value
`define EMWC_ID_VALUE 32'h0000_5a01

`endif

// File: testbench/emwc_cpu_model.sv
// Model of the emulated processor's external bus interface.
// Assumes the answer is registered one clock after the request edge.
`timescale 1ns/10ps

module emwc_cpu_model
  import emwc_pkg::*;
(
  input wire logic pclk,
  input wire emwc_ans_t ans,
  output emwc_req_t req
);
  // Bus never issues power-save stops here, so no NOP spacing arises
  initial begin
    req = '0;
  end

  // ------------------------------------------------------------------
  // One access: pulse for one cycle, then scramble the released lines
  // ------------------------------------------------------------------
  task access(input logic e, input logic [31:0] a, output emwc_ans_t r);
    @(posedge pclk);
    req <= '{valid: 1'b1, emu: e, addr: a};
    @(posedge pclk);
    req <= '{valid: 1'b0, emu: ~e, addr: ~a};
    // Answer is launched at this edge; take it once it has settled
    @(negedge pclk);
    r = ans;
  endtask : access
endmodule : emwc_cpu_model

// File: testbench/tb_top.sv
// Self-checking bench of the emulation memory wait controller.
// Assumes the package compiles first and the core answers in one cycle.
`timescale 1ns/10ps

module tb_top
  import emwc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rs, q, a;
  logic [1:0] mode;
  emwc_req_t req;
  emwc_ans_t ans, got;
  int error_cnt, tests_run, data_wait_config, address_wait_config, bcc, map_errs;
  int fr [6] = '{10, 24, 25, 40, 41, 60};
  logic [31:0] rst_v [5] = '{32'h0, 32'h7, 32'h3, 32'h3, 32'ha};

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  emwc_core #(.ADDR_W(12)) emwc_core_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .emulation_memory_wait_mask_select(mode), .req(req), .ans(ans));
  emwc_cpu_model emwc_cpu_model_inst (.pclk(pclk), .ans(ans), .req(req));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      error_cnt++;
      close_out();
    end
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reference wait decision
  function emwc_ans_t exp_ans(int md, int f, logic map);
    emwc_ans_t x;
    x = '0;
    x.valid = 1'b1;
    x.emu_hit = e && !(map && a >= 32'h0400_0000);
    if (x.emu_hit) begin
      x.data_waits = 4'((md == 1) ? 1 : (md == 2) ? ((data_wait_config == 0) ? 1 : data_wait_config) : 0);
      x.data_waits += 4'((f < 25) ? 0 : (f <= 40) ? 1 : 2);
      x.idle_cycles = 2'((md == 2) ? bcc : 0);
    end else begin
      x.data_waits = 4'(data_wait_config);
      x.addr_waits = 2'(address_wait_config);
      x.idle_cycles = 2'(bcc);
      x.ext_wait_en = (md != 0);
    end
    return x;
  endfunction : exp_ans

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode = 2'h0;
    error_cnt = 0;
    tests_run = 0;
    map_errs = 0;
    rs = 32'hbd0113ac;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reset value", rst_v[i], q);
    end
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, q);
    for (int f = 0; f < 6; f++) begin
      for (int md = 0; md < 4; md++) begin
        rs = lfsr(rs);
        data_wait_config = rs[3:0] % 14;
        address_wait_config = rs[5:4];
        bcc = rs[7:6];
        apb(1'b1, 12'h010, fr[f]);
        apb(1'b1, 12'h004, data_wait_config);
        apb(1'b1, 12'h008, address_wait_config);
        apb(1'b1, 12'h00c, bcc);
        apb(1'b1, 12'h000, {28'h0, rs[8], rs[9], 2'h0});
        mode <= md[1:0];
        for (int k = 0; k < 3; k++) begin
          e = (k != 1);
          a = (k == 2) ? 32'h0400_0000 + rs[15:10] : {6'h0, rs[31:6]};
          emwc_cpu_model_inst.access(e, a, got);
          if (e && rs[8] && k == 2) begin
            map_errs++;
          end
          chk("answer", {21'h0, exp_ans(md, fr[f], rs[8])}, {21'h0, got});
        end
      end
    end
    apb(1'b0, 12'h018, 32'h0);
    chk("id", 32'h0000_5a01, q);
    apb(1'b0, 12'h014, 32'h0);
    chk("status", {14'h0, 2'h3, 8'(map_errs), 8'h48}, q);
    close_out();
  end
endmodule : tb_top
